// ---- core/lagen_ea.sv ----
// effective address adder: base plus scaled index plus displacement
`timescale 1ns/1ns
`default_nettype none
module lagen_ea
  import lagen_pkg::*;
#(
  parameter int W = 32
) (
  input wire logic [W-1:0] base,
  input wire logic base_use,
  input wire logic [W-1:0] index,
  input wire logic index_use,
  input wire logic [1:0] scale,
  input wire logic [W-1:0] disp,
  input wire logic disp_use,
  input wire logic addr16,
  output logic [W-1:0] ea
);
  // the adder must hold a full linear offset
  if (W < LAGEN_LIN_W) begin : g_bad_w
    $error("lagen_ea: width too small");
  end
  logic [W-1:0] b_term;
  logic [W-1:0] i_term;
  logic [W-1:0] d_term;
  logic [W-1:0] sum;
  // only components that are supplied enter the sum
  always_comb begin
    b_term = base_use ? base : '0;
    i_term = index_use ? (index << scale) : '0;
    d_term = disp_use ? disp : '0;
    sum = b_term + i_term + d_term;
    ea = addr16 ? {{(W-LAGEN_REAL_EA_W){1'b0}}, sum[LAGEN_REAL_EA_W-1:0]} : sum;
  end
endmodule
`default_nettype wire

// ---- core/lagen_pkg.sv ----
// package of constants and types for the linear address generator
package lagen_pkg;
  // ----------------------------------------------------------------
  // widths and field positions
  // ----------------------------------------------------------------
  localparam int LAGEN_LIN_W = 32;
  localparam int LAGEN_PHYS_W = 24;
  localparam int LAGEN_SEL_W = 16;
  localparam int LAGEN_REAL_SHIFT = 4;
  localparam int LAGEN_REAL_W = 20;
  localparam int LAGEN_PAGE_OFS_W = 12;
  localparam int LAGEN_CTRL_PE_BIT = 0;
  localparam int LAGEN_CTRL_PG_BIT = 31;
  localparam int LAGEN_REAL_EA_W = 16;
  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [31:0] LAGEN_RST_ADDR = 32'h0000_0000;
  // ----------------------------------------------------------------
  // segment register choice and reference kinds
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    LAGEN_SEG_EXTRA_ONE   = 3'b000,
    LAGEN_SEG_CODE        = 3'b001,
    LAGEN_SEG_STACK       = 3'b010,
    LAGEN_SEG_DATA        = 3'b011,
    LAGEN_SEG_EXTRA_TWO   = 3'b100,
    LAGEN_SEG_EXTRA_THREE = 3'b101
  } lagen_seg_e;
  typedef enum logic [1:0] {
    LAGEN_REF_DATA  = 2'b00,
    LAGEN_REF_STACK = 2'b01,
    LAGEN_REF_FETCH = 2'b10,
    LAGEN_REF_STRDST = 2'b11
  } lagen_ref_e;
  typedef enum logic [1:0] {
    LAGEN_SZ_BYTE  = 2'b00,
    LAGEN_SZ_WORD  = 2'b01,
    LAGEN_SZ_DWORD = 2'b10
  } lagen_size_e;
endpackage

// ---- core/lagen_seg_sel.sv ----
// segment register selection with default and override
`timescale 1ns/1ns
`default_nettype none
module lagen_seg_sel
  import lagen_pkg::*;
(
  input wire lagen_ref_e ref_kind,
  input wire logic base_is_stack,
  input wire logic ovr_valid,
  input wire lagen_seg_e ovr_seg,
  output var lagen_seg_e seg
);
  // fetch, stack and string targets ignore any override
  always_comb begin
    case (ref_kind)
      LAGEN_REF_FETCH: seg = LAGEN_SEG_CODE;
      LAGEN_REF_STACK: seg = LAGEN_SEG_STACK;
      LAGEN_REF_STRDST: seg = LAGEN_SEG_EXTRA_ONE;
      LAGEN_REF_DATA: begin
        if (ovr_valid) begin
          seg = ovr_seg;
        end else if (base_is_stack) begin
          seg = LAGEN_SEG_STACK;
        end else begin
          seg = LAGEN_SEG_DATA;
        end
      end
      default: seg = LAGEN_SEG_DATA;
    endcase
  end
endmodule
`default_nettype wire

// ---- core/lagen_top.sv ----
// linear and physical address generation stage
// ------------------------------------------------------------------
// Notes on behaviour
// - multi-byte operands little-endian, least significant byte at lowest address
// - operand address is the byte address of its least significant byte
// - offset is sum of supplied base, index and displacement
// - real mode: selector shifted left four plus effective address
// - protected mode: 32-bit segment base plus effective address
// - paging off: lower 24 bits of linear address drive physical address
// - paging on: linear address handed to paging unit, 24-bit physical result
// - paged memory uses fixed 4K byte pages
// - default segment: data, stack, or code with instruction pointer for fetch
// - override prefixes select segments explicitly; only way to extra segments two and three
// - segment sizes from 1 byte to 4 gigabytes
// - segment bases may overlap freely, including all at zero
// - default operand size 32 or 16 per code size; prefix swaps it
// - protected mode while control bit 0 set, real mode when clear
// - paging unit enabled while control bits 31 and 0 are both set
// ------------------------------------------------------------------
`timescale 1ns/1ns
`default_nettype none
module lagen_top
  import lagen_pkg::*;
(
  input wire logic SYS_CLK,
  input wire logic RST_N,
  input wire logic [31:0] CTRL_WORD,
  input wire logic REQ_VALID,
  input wire lagen_ref_e REQ_KIND,
  input wire logic BASE_IS_STACK,
  input wire logic OVR_VALID,
  input wire lagen_seg_e OVR_SEG,
  input wire logic [31:0] BASE_VAL,
  input wire logic BASE_USE,
  input wire logic [31:0] INDEX_VAL,
  input wire logic INDEX_USE,
  input wire logic [1:0] SCALE,
  input wire logic [31:0] DISP_VAL,
  input wire logic DISP_USE,
  input wire logic [31:0] INSN_PTR,
  input wire logic CODE_32,
  input wire logic OPSIZE_PFX,
  input wire logic BYTE_OP,
  input wire logic ADDR16,
  input wire logic [15:0] SEL_CODE,
  input wire logic [15:0] SEL_STACK,
  input wire logic [15:0] DATA_SEGMENT_REG,
  input wire logic [15:0] EXTRA_SEGMENT_ONE,
  input wire logic [15:0] EXTRA_SEGMENT_TWO,
  input wire logic [15:0] EXTRA_SEGMENT_THREE,
  input wire logic [31:0] BASE_CODE,
  input wire logic [31:0] BASE_STACK,
  input wire logic [31:0] BASE_DATA,
  input wire logic [31:0] BASE_EXTRA_ONE,
  input wire logic [31:0] BASE_EXTRA_TWO,
  input wire logic [31:0] BASE_EXTRA_THREE,
  input wire logic [31:0] STORE_DATA,
  output logic ADDR_VALID,
  output logic [23:0] PHYS_ADDR,
  output logic PAGE_REQ,
  output logic [31:0] LIN_ADDR,
  output logic [19:0] PAGE_NUM,
  output logic [11:0] PAGE_OFS,
  output var lagen_seg_e SEG_USED,
  output var lagen_size_e OP_SIZE,
  output logic [3:0] BYTE_EN,
  output logic [31:0] BYTE_LANES,
  output logic PROT_MODE,
  output logic PAGING_ON
);
  // ----------------------------------------------------------------
  // elaboration checks on the package widths
  // ----------------------------------------------------------------
  // the ports are fixed, so the package widths must agree with them
  if (LAGEN_LIN_W != $bits(LIN_ADDR) || LAGEN_PHYS_W != $bits(PHYS_ADDR)) begin : g_bad_addr_w
    $error("lagen_top: address widths differ from the ports");
  end
  // real mode sum must fit the selector shifted by four
  if (LAGEN_REAL_W != LAGEN_SEL_W + LAGEN_REAL_SHIFT) begin : g_bad_real_w
    $error("lagen_top: real mode width does not match selector shift");
  end
  // page offset width must agree with its port
  if (LAGEN_PAGE_OFS_W != $bits(PAGE_OFS)) begin : g_bad_page_w
    $error("lagen_top: page offset width differs from the port");
  end
  // both mode bits must sit inside the control word
  if (LAGEN_CTRL_PG_BIT >= 32 || LAGEN_CTRL_PE_BIT >= 32) begin : g_bad_ctrl_bit
    $error("lagen_top: control bit outside control word");
  end

  // ----------------------------------------------------------------
  // effective address and segment choice
  // ----------------------------------------------------------------
  logic [31:0] ea;
  lagen_seg_e seg;
  lagen_ea #(.W(LAGEN_LIN_W)) u_ea (
    .base(BASE_VAL),
    .base_use(BASE_USE),
    .index(INDEX_VAL),
    .index_use(INDEX_USE),
    .scale(SCALE),
    .disp(DISP_VAL),
    .disp_use(DISP_USE),
    .addr16(ADDR16),
    .ea(ea)
  );
  lagen_seg_sel u_seg (
    .ref_kind(REQ_KIND),
    .base_is_stack(BASE_IS_STACK),
    .ovr_valid(OVR_VALID),
    .ovr_seg(OVR_SEG),
    .seg(seg)
  );

  // ----------------------------------------------------------------
  // address translation, next values
  // ----------------------------------------------------------------
  logic protection_enable;
  logic paging_enable;
  logic [31:0] offset;
  logic [15:0] sel;
  logic [31:0] seg_base;
  logic [31:0] real_lin;
  logic [31:0] lin;
  logic next_addr_valid;
  logic [23:0] next_phys_addr;
  logic next_page_req;
  logic [31:0] next_lin_addr;
  lagen_seg_e next_seg_used;
  lagen_size_e next_op_size;
  logic [3:0] next_byte_en;
  logic [31:0] next_byte_lanes;
  logic next_prot_mode;
  logic next_paging_on;
  logic [19:0] next_page_num;
  logic [11:0] next_page_ofs;

  // mode bits and chosen selector, base and offset
  always_comb begin
    protection_enable = CTRL_WORD[LAGEN_CTRL_PE_BIT];
    paging_enable = CTRL_WORD[LAGEN_CTRL_PG_BIT] & protection_enable;
    offset = (REQ_KIND == LAGEN_REF_FETCH) ? INSN_PTR : ea;
    case (seg)
      LAGEN_SEG_CODE: begin
        sel = SEL_CODE;
        seg_base = BASE_CODE;
      end
      LAGEN_SEG_STACK: begin
        sel = SEL_STACK;
        seg_base = BASE_STACK;
      end
      LAGEN_SEG_EXTRA_ONE: begin
        sel = EXTRA_SEGMENT_ONE;
        seg_base = BASE_EXTRA_ONE;
      end
      LAGEN_SEG_EXTRA_TWO: begin
        sel = EXTRA_SEGMENT_TWO;
        seg_base = BASE_EXTRA_TWO;
      end
      LAGEN_SEG_EXTRA_THREE: begin
        sel = EXTRA_SEGMENT_THREE;
        seg_base = BASE_EXTRA_THREE;
      end
      default: begin
        sel = DATA_SEGMENT_REG;
        seg_base = BASE_DATA;
      end
    endcase
  end

  // linear address in either mode, free base overlap, any segment size
  always_comb begin
    real_lin = ({16'h0000, sel} << LAGEN_REAL_SHIFT) + offset;
    real_lin = {12'h000, real_lin[LAGEN_REAL_W-1:0]};
    if (protection_enable) begin
      lin = seg_base + offset;
    end else begin
      lin = real_lin;
    end
  end

  // outputs: truncate or hand to paging unit, plus size and byte lanes
  always_comb begin
    next_addr_valid = REQ_VALID & ~paging_enable;
    next_page_req = REQ_VALID & paging_enable;
    next_phys_addr = PHYS_ADDR;
    next_lin_addr = LIN_ADDR;
    next_seg_used = SEG_USED;
    next_op_size = OP_SIZE;
    next_byte_en = BYTE_EN;
    next_byte_lanes = BYTE_LANES;
    next_prot_mode = protection_enable;
    next_paging_on = paging_enable;
    next_page_num = PAGE_NUM;
    next_page_ofs = PAGE_OFS;
    if (REQ_VALID) begin
      next_lin_addr = lin;
      // page number and offset split at the 4K boundary
      next_page_num = lin[LAGEN_LIN_W-1:LAGEN_PAGE_OFS_W];
      next_page_ofs = lin[LAGEN_PAGE_OFS_W-1:0];
      next_phys_addr = paging_enable ? PHYS_ADDR : lin[LAGEN_PHYS_W-1:0];
      next_seg_used = seg;
      if (BYTE_OP) begin
        next_op_size = LAGEN_SZ_BYTE;
      end else if (CODE_32 ^ OPSIZE_PFX) begin
        next_op_size = LAGEN_SZ_DWORD;
      end else begin
        next_op_size = LAGEN_SZ_WORD;
      end
      // least significant byte sits in lane 0 at the operand address
      case (next_op_size)
        LAGEN_SZ_BYTE: next_byte_en = 4'h1;
        LAGEN_SZ_WORD: next_byte_en = 4'h3;
        default: next_byte_en = 4'hf;
      endcase
      next_byte_lanes = STORE_DATA;
    end
  end

  // ----------------------------------------------------------------
  // result register stage
  // ----------------------------------------------------------------
  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      ADDR_VALID <= 1'b0;
      PAGE_REQ <= 1'b0;
      PHYS_ADDR <= LAGEN_RST_ADDR[LAGEN_PHYS_W-1:0];
      LIN_ADDR <= LAGEN_RST_ADDR;
      SEG_USED <= LAGEN_SEG_DATA;
      OP_SIZE <= LAGEN_SZ_BYTE;
      BYTE_EN <= 4'h0;
      BYTE_LANES <= 32'h0000_0000;
      PROT_MODE <= 1'b0;
      PAGING_ON <= 1'b0;
      PAGE_NUM <= 20'h00000;
      PAGE_OFS <= 12'h000;
    end else begin
      ADDR_VALID <= next_addr_valid;
      PAGE_REQ <= next_page_req;
      PHYS_ADDR <= next_phys_addr;
      LIN_ADDR <= next_lin_addr;
      SEG_USED <= next_seg_used;
      OP_SIZE <= next_op_size;
      BYTE_EN <= next_byte_en;
      BYTE_LANES <= next_byte_lanes;
      PROT_MODE <= next_prot_mode;
      PAGING_ON <= next_paging_on;
      PAGE_NUM <= next_page_num;
      PAGE_OFS <= next_page_ofs;
    end
  end
endmodule
`default_nettype wire

// ---- dv/lagen_chk_assertions.sv ----
// checker of answer timing and address forming at the stage ports
`timescale 1ns/1ns
`default_nettype none
module lagen_chk
  import lagen_pkg::*;
(
  input wire logic SYS_CLK,
  input wire logic RST_N,
  input wire logic [31:0] CTRL_WORD,
  input wire logic REQ_VALID,
  input wire logic [31:0] STORE_DATA,
  input wire logic ADDR_VALID,
  input wire logic PAGE_REQ,
  input wire logic [23:0] PHYS_ADDR,
  input wire logic [31:0] LIN_ADDR,
  input wire logic [19:0] PAGE_NUM,
  input wire logic [11:0] PAGE_OFS,
  input wire logic [31:0] BYTE_LANES,
  input wire logic PROT_MODE,
  input wire logic PAGING_ON
);
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (!RST_N);
  wire logic out_v;
  // any answer strobe
  assign out_v = ADDR_VALID | PAGE_REQ;
  // a request and its single answer one cycle later
  sequence s_req; REQ_VALID; endsequence
  sequence s_ans; ADDR_VALID != PAGE_REQ; endsequence
  AST_ANSWER: assert property (s_req |=> s_ans)
    else $error("request without one answer");
  AST_NO_EXTRA: assert property (!REQ_VALID |=> !out_v)
    else $error("answer without request");
  AST_TRUNC: assert property (ADDR_VALID |-> PHYS_ADDR == LIN_ADDR[23:0])
    else $error("physical address not lower linear bits");
  AST_PAGE_SPLIT: assert property (PAGE_REQ |-> {PAGE_NUM, PAGE_OFS} == LIN_ADDR)
    else $error("page split wrong");
  AST_PAGED_ONLY: assert property (out_v |-> PAGE_REQ == PAGING_ON)
    else $error("wrong answer strobe for paging state");
  AST_REAL_1M: assert property (out_v && !PROT_MODE |-> LIN_ADDR[31:20] == 12'h000)
    else $error("real mode address above one megabyte");
  AST_PE: assert property ($past(RST_N) |-> PROT_MODE == $past(CTRL_WORD[0]))
    else $error("protected mode flag wrong");
  AST_PG: assert property ($past(RST_N) |->
    PAGING_ON == ($past(CTRL_WORD[31]) & $past(CTRL_WORD[0])))
    else $error("paging flag wrong");
  AST_LANES: assert property (s_req |=> BYTE_LANES == $past(STORE_DATA))
    else $error("byte lanes wrong");
  // the physical bus is left alone while the paging unit owns translation
  AST_PHYS_HOLD: assert property (PAGE_REQ |-> $stable(PHYS_ADDR))
    else $error("physical address moved while paging");
endmodule
bind lagen_top lagen_chk i_chk (.SYS_CLK(SYS_CLK), .RST_N(RST_N), .CTRL_WORD(CTRL_WORD),
  .REQ_VALID(REQ_VALID), .STORE_DATA(STORE_DATA), .ADDR_VALID(ADDR_VALID),
  .PAGE_REQ(PAGE_REQ), .PHYS_ADDR(PHYS_ADDR), .LIN_ADDR(LIN_ADDR), .PAGE_NUM(PAGE_NUM),
  .PAGE_OFS(PAGE_OFS), .BYTE_LANES(BYTE_LANES), .PROT_MODE(PROT_MODE),
  .PAGING_ON(PAGING_ON));
`default_nettype wire

// ---- dv/lagen_seg_model.sv ----
// segment state model: selectors and bases offered to the stage
`timescale 1ns/1ns
`default_nettype none
module lagen_seg_model
  import lagen_pkg::*;
(
  input wire logic flat,
  input wire logic [31:0] seed,
  output logic [15:0] sel [0:5],
  output logic [31:0] base [0:5]
);
  // one entry per segment code; flat puts all bases at zero
  always_comb begin
    for (int i = 0; i < 6; i++) begin
      sel[i] = seed[15:0] ^ (16'h1111 * 16'(i));
      base[i] = flat ? 32'h0000_0000 : seed + 32'h1357_9bdf * i;
    end
  end
endmodule
`default_nettype wire

// ---- dv/lagen_top_tb.sv ----
// self-checking bench of the linear address stage
`timescale 1ns/1ns
`default_nettype none
module lagen_top_tb
  import lagen_pkg::*;
;
  logic SYS_CLK, RST_N, REQ_VALID, BASE_IS_STACK, OVR_VALID, BASE_USE, INDEX_USE, DISP_USE;
  logic CODE_32, OPSIZE_PFX, BYTE_OP, ADDR16, flat, ADDR_VALID, PAGE_REQ, PROT_MODE, PAGING_ON;
  logic [1:0] SCALE;
  logic [3:0] BYTE_EN;
  logic [11:0] PAGE_OFS;
  logic [19:0] PAGE_NUM;
  logic [23:0] PHYS_ADDR;
  logic [31:0] CTRL_WORD, BASE_VAL, INDEX_VAL, DISP_VAL, INSN_PTR, STORE_DATA, LIN_ADDR;
  logic [31:0] BYTE_LANES, seed;
  lagen_ref_e REQ_KIND;
  lagen_seg_e OVR_SEG, SEG_USED;
  lagen_size_e OP_SIZE;
  logic [15:0] sel [0:5];
  logic [31:0] base [0:5];
  typedef struct {
    logic [31:0] lin; lagen_seg_e seg; lagen_size_e sz; logic [3:0] be;
    logic pe; logic pg; logic [31:0] lanes;
  } lagen_exp_s;
  lagen_exp_s q[$];
  lagen_exp_s m;
  int bad_count = 0;
  int num_checks = 0;
  lagen_seg_model i_seg (.flat(flat), .seed(seed), .sel(sel), .base(base));
  lagen_top i_dut (.SYS_CLK(SYS_CLK), .RST_N(RST_N), .CTRL_WORD(CTRL_WORD),
    .REQ_VALID(REQ_VALID), .REQ_KIND(REQ_KIND), .BASE_IS_STACK(BASE_IS_STACK),
    .OVR_VALID(OVR_VALID), .OVR_SEG(OVR_SEG), .BASE_VAL(BASE_VAL), .BASE_USE(BASE_USE),
    .INDEX_VAL(INDEX_VAL), .INDEX_USE(INDEX_USE), .SCALE(SCALE), .DISP_VAL(DISP_VAL),
    .DISP_USE(DISP_USE), .INSN_PTR(INSN_PTR), .CODE_32(CODE_32), .OPSIZE_PFX(OPSIZE_PFX),
    .BYTE_OP(BYTE_OP), .ADDR16(ADDR16), .STORE_DATA(STORE_DATA), .ADDR_VALID(ADDR_VALID),
    .PHYS_ADDR(PHYS_ADDR), .PAGE_REQ(PAGE_REQ), .LIN_ADDR(LIN_ADDR), .PAGE_NUM(PAGE_NUM),
    .PAGE_OFS(PAGE_OFS), .SEG_USED(SEG_USED), .OP_SIZE(OP_SIZE), .BYTE_EN(BYTE_EN),
    .BYTE_LANES(BYTE_LANES), .PROT_MODE(PROT_MODE), .PAGING_ON(PAGING_ON),
    .SEL_CODE(sel[1]), .SEL_STACK(sel[2]), .DATA_SEGMENT_REG(sel[3]),
    .EXTRA_SEGMENT_ONE(sel[0]), .EXTRA_SEGMENT_TWO(sel[4]), .EXTRA_SEGMENT_THREE(sel[5]),
    .BASE_CODE(base[1]), .BASE_STACK(base[2]), .BASE_DATA(base[3]),
    .BASE_EXTRA_ONE(base[0]), .BASE_EXTRA_TWO(base[4]), .BASE_EXTRA_THREE(base[5]));
  // clock of 4 ns
  initial begin
    SYS_CLK = 0;
    forever #2 SYS_CLK = ~SYS_CLK;
  end
  task chk(input bit c, input string msg);
    num_checks++;
    if (!c) begin
      bad_count++;
      $display("[ERR] %0t %s", $time, msg);
    end
  endtask
  task results;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // expected answer worked out from the inputs now applied
  function automatic lagen_exp_s expect_of();
    lagen_exp_s e;
    logic [31:0] off;
    lagen_seg_e s;
    off = (BASE_USE ? BASE_VAL : 32'h0) + ((INDEX_USE ? INDEX_VAL : 32'h0) << SCALE)
      + (DISP_USE ? DISP_VAL : 32'h0);
    if (ADDR16) off[31:16] = 16'h0000;
    s = OVR_VALID ? OVR_SEG : BASE_IS_STACK ? LAGEN_SEG_STACK : LAGEN_SEG_DATA;
    if (REQ_KIND == LAGEN_REF_STACK) s = LAGEN_SEG_STACK;
    if (REQ_KIND == LAGEN_REF_STRDST) s = LAGEN_SEG_EXTRA_ONE;
    if (REQ_KIND == LAGEN_REF_FETCH) begin
      s = LAGEN_SEG_CODE;
      off = INSN_PTR;
    end
    e.pe = CTRL_WORD[0];
    e.pg = CTRL_WORD[0] & CTRL_WORD[31];
    e.lin = e.pe ? base[s] + off : ({sel[s], 4'h0} + off) & 32'h000f_ffff;
    e.sz = BYTE_OP ? LAGEN_SZ_BYTE : (CODE_32 ^ OPSIZE_PFX) ? LAGEN_SZ_DWORD : LAGEN_SZ_WORD;
    e.be = BYTE_OP ? 4'h1 : (CODE_32 ^ OPSIZE_PFX) ? 4'hf : 4'h3;
    e.seg = s;
    e.lanes = STORE_DATA;
    return e;
  endfunction
  // one cycle of random stimulus, noting the expected answer
  task automatic drive(input logic v);
    REQ_VALID = v;
    REQ_KIND = lagen_ref_e'($urandom % 4);
    OVR_SEG = lagen_seg_e'($urandom % 6);
    {OVR_VALID, BASE_IS_STACK, BASE_USE, INDEX_USE, DISP_USE, CODE_32} = 6'($urandom);
    {OPSIZE_PFX, BYTE_OP, ADDR16, SCALE} = 5'($urandom);
    if (REQ_KIND == LAGEN_REF_FETCH) ADDR16 = 1'b0;
    {CTRL_WORD, BASE_VAL, INDEX_VAL} = {$urandom, $urandom, $urandom};
    {DISP_VAL, INSN_PTR, STORE_DATA} = {$urandom, $urandom, $urandom};
    if (v) q.push_back(expect_of());
    @(posedge SYS_CLK);
    #1;
  endtask
  // answers compared against the oldest note
  always @(posedge SYS_CLK) begin
    #2;
    if (ADDR_VALID === 1'b1 || PAGE_REQ === 1'b1) begin
      if (q.size() == 0) chk(1'b0, "answer without request");
      else begin
        m = q.pop_front();
        chk(LIN_ADDR === m.lin, "linear address");
        chk(PAGE_REQ === m.pg && PAGING_ON === m.pg, "paging state");
        if (m.pg) chk({PAGE_NUM, PAGE_OFS} === m.lin, "page split");
        else chk(PHYS_ADDR === m.lin[23:0], "physical address");
        chk(SEG_USED === m.seg, "segment choice");
        chk(PROT_MODE === m.pe, "protected mode");
        chk(OP_SIZE === m.sz && BYTE_EN === m.be, "operand size");
        chk(BYTE_LANES === m.lanes, "byte lanes");
      end
    end
  end
  // two reset phases: segmented, then flat bases
  initial begin
    void'($urandom(80));
    RST_N = 0;
    flat = 0;
    seed = 0;
    for (int p = 0; p < 2; p++) begin
      RST_N = 0;
      repeat (3) drive(1'b0);
      chk(SEG_USED === LAGEN_SEG_DATA && ADDR_VALID === 1'b0, "reset strobe");
      chk(LIN_ADDR === 32'h0 && PAGE_REQ === 1'b0, "reset address");
      RST_N = 1;
      flat = p[0];
      seed = $urandom;
      drive(1'b0);
      repeat (300) drive($urandom % 4 != 0);
      drive(1'b0);
      for (int k = 0; k < 8 && q.size() != 0; k++) drive(1'b0);
      if (q.size() != 0) chk(1'b0, "answer missing");
    end
    results;
  end
endmodule
`default_nettype wire
